// ===== core/dio_edge_io.sv
// How it works
// - Core tristate control always passes registers
// - Single and plain double rate: one flop
// - Geared mode: three extra fast-clocked enable registers
// - Interference correction only in geared mode
// - Each lane keeps its own correction setting
// - Long runs get no stretch
// - Isolated one in 010 is stretched
// - Isolated zero in 101 is stretched
// - Stretch amount is a 3-bit control
// - Selectable polarity picks read capture edge
// - Polarity re-evaluated at every read start
// - First strobe rise after preamble sets polarity
// - Leveling yields polarity and latency signals
// - Both read and write leveling provided
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
module dio_edge_io #(
    parameter int LANES     = dio_pkg::LANES,
    parameter int BURST_LEN = dio_pkg::BURST_LEN
) (
    // Clocks, reset, enable
    input  wire logic                        ref_clk_i,
    input  wire logic                        reset_n_i,
    input  wire logic                        ce_i,
    input  wire logic                        fast_gear_clk_a_i,
    input  wire logic                        fast_gear_clk_b_i,
    input  wire logic                        strobe_clk_i,
    // Register port
    input  wire logic [dio_pkg::ADDR_W-1:0]  reg_addr_i,
    input  wire logic [31:0]                 reg_wdata_i,
    input  wire logic                        reg_wr_i,
    input  wire logic                        reg_rd_i,
    output logic      [31:0]                 reg_rdata_o,
    // Output path
    input  wire logic                        tristate_ctl_in_i,
    input  wire logic [LANES-1:0]            out_data_i,
    output logic      [LANES-1:0]            out_data_o,
    output logic      [LANES*dio_pkg::ISI_W-1:0] isi_stretch_o,
    output logic                             buf_oe_o,
    // Read path
    input  wire logic [dio_pkg::DQ_W-1:0]    rd_dq_i,
    input  wire logic                        rd_start_i,
    output logic      [dio_pkg::DQ_W-1:0]    rd_data_o,
    output logic                             rd_valid_o,
    output logic                             read_capture_polarity_o,
    output logic                             read_capture_latency_o,
    // Write leveling
    input  wire logic                        wr_lev_fb_i,
    output logic                             wr_lev_en_o,
    output logic      [dio_pkg::WLEV_W-1:0]  wr_lev_delay_o
);

    // =====================================================================
    // Reset release
    logic rst_s1_q;
    logic rst_n_q;

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    function automatic logic isi_hit(input logic [2:0] w);
        isi_hit = (w == 3'b010) || (w == 3'b101);
    endfunction

    // =====================================================================
    // Registers
    dio_pkg::dio_cfg_t      cfg_q;
    logic [dio_pkg::ISI_W-1:0] isi_q [LANES];
    logic                   pol_q;
    logic                   pol_vld_q;
    dio_pkg::dio_rd_st_t    st_q;
    logic                   wfb_s1_q;
    logic                   wfb_q;
    logic                   x2;

    assign x2 = (cfg_q.mode == dio_pkg::DIO_MODE_X2);

    always_ff @(posedge ref_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
            cfg_q <= dio_pkg::CFG_RST;
        else if (ce_i && reg_wr_i && reg_addr_i == dio_pkg::OFF_CTRL)
        begin
            cfg_q.mode    <= dio_pkg::dio_mode_t'(reg_wdata_i[dio_pkg::CTRL_MODE +: 2]);
            cfg_q.rlat    <= reg_wdata_i[dio_pkg::CTRL_RLAT];
            cfg_q.wlev_en <= reg_wdata_i[dio_pkg::CTRL_WLEV];
        end
        else if (ce_i && reg_wr_i && reg_addr_i == dio_pkg::OFF_WLEV)
            cfg_q.wlev_dly <= reg_wdata_i[dio_pkg::WLEV_W-1:0];
    end

    for (genvar g = 0; g < LANES; g++)
    begin : g_isi_reg
        localparam logic [dio_pkg::ADDR_W-1:0] OFF =
            (g < dio_pkg::ISI_PER_WORD) ? dio_pkg::OFF_ISI_LO : dio_pkg::OFF_ISI_HI;
        localparam int LSB = (g % dio_pkg::ISI_PER_WORD) * dio_pkg::ISI_W;
        always_ff @(posedge ref_clk_i or negedge rst_n_q)
        begin
            if (!rst_n_q)
                isi_q[g] <= dio_pkg::ISI_RST;
            else if (ce_i && reg_wr_i && reg_addr_i == OFF)
                isi_q[g] <= reg_wdata_i[LSB +: dio_pkg::ISI_W];
        end
    end

    // Write-leveling feedback is a pin, so it is synchronised first.
    always_ff @(posedge ref_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            wfb_s1_q <= 1'b0;
            wfb_q    <= 1'b0;
        end
        else if (ce_i)
        begin
            wfb_s1_q <= wr_lev_fb_i;
            wfb_q    <= wfb_s1_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
            reg_rdata_o <= 32'h0;
        else if (ce_i)
        begin
            reg_rdata_o <= 32'h0;
            if (reg_rd_i)
            begin
                case (reg_addr_i)
                    dio_pkg::OFF_CTRL:
                    begin
                        reg_rdata_o[dio_pkg::CTRL_MODE +: 2] <= cfg_q.mode;
                        reg_rdata_o[dio_pkg::CTRL_RLAT]      <= cfg_q.rlat;
                        reg_rdata_o[dio_pkg::CTRL_WLEV]      <= cfg_q.wlev_en;
                    end
                    dio_pkg::OFF_ISI_LO, dio_pkg::OFF_ISI_HI:
                    begin
                        for (int i = 0; i < LANES; i++)
                            if ((i < dio_pkg::ISI_PER_WORD) == (reg_addr_i == dio_pkg::OFF_ISI_LO))
                                reg_rdata_o[(i % dio_pkg::ISI_PER_WORD) * dio_pkg::ISI_W
                                    +: dio_pkg::ISI_W] <= isi_q[i];
                    end
                    dio_pkg::OFF_STAT:
                    begin
                        reg_rdata_o[dio_pkg::STAT_POL]  <= pol_q;
                        reg_rdata_o[dio_pkg::STAT_LAT]  <= cfg_q.rlat;
                        reg_rdata_o[dio_pkg::STAT_BUSY] <= (st_q != dio_pkg::RD_IDLE);
                        reg_rdata_o[dio_pkg::STAT_WFB]  <= wfb_q;
                        reg_rdata_o[dio_pkg::STAT_VLD]  <= pol_vld_q;
                    end
                    dio_pkg::OFF_WLEV:
                        reg_rdata_o[dio_pkg::WLEV_W-1:0] <= cfg_q.wlev_dly;
                    default:
                        reg_rdata_o <= 32'h0;
                endcase
            end
        end
    end

    assign wr_lev_en_o    = cfg_q.wlev_en;
    assign wr_lev_delay_o = cfg_q.wlev_dly;

    // =====================================================================
    // Tristate path
    logic ts_q;
    logic gear_s1_q;
    logic gear_a_q;
    logic gear_b_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
            ts_q <= 1'b1;
        else if (ce_i)
            ts_q <= tristate_ctl_in_i;
    end

    always_ff @(posedge fast_gear_clk_a_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            gear_s1_q <= 1'b1;
            gear_a_q  <= 1'b1;
        end
        else
        begin
            gear_s1_q <= ts_q;
            gear_a_q  <= gear_s1_q;
        end
    end

    // The second gearing clock is phase-locked to the first, so one flop retimes safely.
    always_ff @(posedge fast_gear_clk_b_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            gear_b_q <= 1'b1;
        else
            gear_b_q <= gear_a_q;
    end

    assign buf_oe_o = x2 ? !gear_b_q : !ts_q;

    // =====================================================================
    // Inter-symbol interference correction
    logic [LANES-1:0] hist0_q;
    logic [LANES-1:0] hist1_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            hist0_q <= '0;
            hist1_q <= '0;
        end
        else if (ce_i)
        begin
            hist0_q <= out_data_i;
            hist1_q <= hist0_q;
        end
    end

    for (genvar g = 0; g < LANES; g++)
    begin : g_isi
        always_ff @(posedge ref_clk_i or negedge rst_n_q)
        begin
            if (!rst_n_q)
            begin
                out_data_o[g]                             <= 1'b0;
                isi_stretch_o[g*dio_pkg::ISI_W +: dio_pkg::ISI_W] <= '0;
            end
            else if (ce_i)
            begin
                out_data_o[g] <= hist0_q[g];
                if (x2 && isi_hit({hist1_q[g], hist0_q[g], out_data_i[g]}))
                    isi_stretch_o[g*dio_pkg::ISI_W +: dio_pkg::ISI_W] <= isi_q[g];
                else
                    isi_stretch_o[g*dio_pkg::ISI_W +: dio_pkg::ISI_W] <= '0;
            end
        end
    end

    // =====================================================================
    // Strobe domain capture
    logic               phase_q;
    logic               cap_tgl_q;
    dio_pkg::dio_cap_t  cap_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
            phase_q <= 1'b0;
        else if (ce_i)
            phase_q <= !phase_q;
    end

    // The strobe runs only inside a read frame, so a synchroniser clocked by it would give
    // the first rise of a read the phase seen during the previous read. The phase goes
    // straight into the capture word instead; the system side reads that word only after
    // the toggle has crossed, long after it has settled.
    always_ff @(posedge strobe_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cap_tgl_q <= 1'b0;
            cap_q     <= '0;
        end
        else
        begin
            cap_q.ph   <= phase_q;
            cap_q.data <= rd_dq_i;
            cap_tgl_q  <= !cap_tgl_q;
        end
    end

    // =====================================================================
    // System clock read side
    logic       t1_q;
    logic       t2_q;
    logic       t3_q;
    logic       edge_q;
    logic       edge_w;
    logic       take_w;
    localparam int CNT_W = $clog2(BURST_LEN + 1);
    logic [CNT_W-1:0] cnt_q;
    logic [dio_pkg::DQ_W-1:0] d0_q;
    logic [dio_pkg::DQ_W-1:0] d1_q;
    logic       v0_q;
    logic       v1_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            t1_q   <= 1'b0;
            t2_q   <= 1'b0;
            t3_q   <= 1'b0;
            edge_q <= 1'b0;
        end
        else if (ce_i)
        begin
            t1_q   <= cap_tgl_q;
            t2_q   <= t1_q;
            t3_q   <= t2_q;
            edge_q <= edge_w;
        end
    end

    assign edge_w = t2_q ^ t3_q;

    always_comb
    begin
        take_w = 1'b0;
        case (st_q)
            dio_pkg::RD_WAIT:  take_w = edge_w && !cap_q.ph;
            dio_pkg::RD_BURST: take_w = pol_q ? edge_q : edge_w;
            default:           take_w = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            st_q      <= dio_pkg::RD_IDLE;
            pol_q     <= 1'b0;
            pol_vld_q <= 1'b0;
            cnt_q     <= '0;
        end
        else if (ce_i)
        begin
            case (st_q)
                dio_pkg::RD_IDLE:
                    if (rd_start_i)
                    begin
                        st_q      <= dio_pkg::RD_WAIT;
                        pol_vld_q <= 1'b0;
                        cnt_q     <= '0;
                    end
                dio_pkg::RD_WAIT:
                    if (edge_w)
                    begin
                        pol_q     <= cap_q.ph;
                        pol_vld_q <= 1'b1;
                        st_q      <= dio_pkg::RD_BURST;
                        cnt_q     <= CNT_W'(take_w);
                    end
                dio_pkg::RD_BURST:
                    if (take_w)
                    begin
                        cnt_q <= cnt_q + 1'b1;
                        if (cnt_q == CNT_W'(BURST_LEN - 1))
                            st_q <= dio_pkg::RD_IDLE;
                    end
                default:
                    st_q <= dio_pkg::RD_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            d0_q <= '0;
            d1_q <= '0;
            v0_q <= 1'b0;
            v1_q <= 1'b0;
        end
        else if (ce_i)
        begin
            v0_q <= take_w;
            v1_q <= v0_q;
            d1_q <= d0_q;
            if (take_w)
                d0_q <= cap_q.data;
        end
    end

    assign rd_data_o               = cfg_q.rlat ? d1_q : d0_q;
    assign rd_valid_o              = cfg_q.rlat ? v1_q : v0_q;
    assign read_capture_polarity_o = pol_q;
    assign read_capture_latency_o  = cfg_q.rlat;

    // =====================================================================
    // Checks
    AST_TS_PLAIN: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
        (ce_i && !x2 && !reg_wr_i) |=> buf_oe_o == !$past(tristate_ctl_in_i))
        else $error("plain-mode enable does not follow tristate input");
    AST_TS_GEAR: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
        (x2 && $past(x2) && $past(x2, 2) && ts_q == $past(ts_q) && ts_q == $past(ts_q, 2))
        |-> buf_oe_o == !ts_q)
        else $error("geared enable does not follow the tristate register");
    AST_ISI_OFF: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
        (ce_i && !x2 && !reg_wr_i) |=> isi_stretch_o == '0)
        else $error("stretch outside geared mode");
    AST_ISI_RUN: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
        (ce_i && out_data_i[0] == hist0_q[0] && hist0_q[0] == hist1_q[0])
        |=> isi_stretch_o[2:0] == '0)
        else $error("stretch on a long run");
    AST_ISI_ONE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
        (ce_i && x2 && !reg_wr_i && {hist1_q[0], hist0_q[0], out_data_i[0]} == 3'b010)
        |=> out_data_o[0] && isi_stretch_o[2:0] == isi_q[0])
        else $error("isolated one not stretched");
    AST_ISI_ZERO: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
        (ce_i && x2 && !reg_wr_i && {hist1_q[0], hist0_q[0], out_data_i[0]} == 3'b101)
        |=> !out_data_o[0] && isi_stretch_o[2:0] == isi_q[0])
        else $error("isolated zero not stretched");
    AST_RD_START: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
        (ce_i && st_q == dio_pkg::RD_IDLE && rd_start_i)
        |=> st_q == dio_pkg::RD_WAIT && !pol_vld_q)
        else $error("read start did not clear polarity");
    AST_POL_SET: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
        (ce_i && st_q == dio_pkg::RD_WAIT && edge_w)
        |=> pol_vld_q && pol_q == $past(cap_q.ph) && st_q == dio_pkg::RD_BURST)
        else $error("first strobe rise did not set polarity");
    AST_POL_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
        (st_q == dio_pkg::RD_BURST ##1 st_q == dio_pkg::RD_BURST) |-> $stable(pol_q))
        else $error("polarity changed inside burst");
    AST_LAT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
        (ce_i && take_w && !cfg_q.rlat && !reg_wr_i) |=> rd_valid_o)
        else $error("read word not delivered");

    COV_BURST_POL: cover property (@(posedge ref_clk_i) disable iff (!rst_n_q)
        st_q == dio_pkg::RD_BURST && pol_q ##1 st_q == dio_pkg::RD_IDLE);
    COV_STRETCH: cover property (@(posedge ref_clk_i) disable iff (!rst_n_q)
        isi_stretch_o != '0);
    COV_GEAR_OE: cover property (@(posedge fast_gear_clk_b_i) disable iff (!reset_n_i)
        x2 && buf_oe_o);

endmodule

// ===== common/dio_pkg.sv
package dio_pkg;

    // =====================================================================
    // Sizes
    localparam int LANES        = 12;
    localparam int DQ_W         = 8;
    localparam int ISI_W        = 3;
    localparam int ISI_PER_WORD = 8;
    localparam int WLEV_W       = 4;
    localparam int BURST_LEN    = 4;
    localparam int ADDR_W       = 5;

    // =====================================================================
    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_ISI_LO = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_ISI_HI = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_STAT   = 5'h0c;
    localparam logic [ADDR_W-1:0] OFF_WLEV   = 5'h10;

    // =====================================================================
    // Field positions and reset values
    localparam int CTRL_MODE = 0;
    localparam int CTRL_RLAT = 2;
    localparam int CTRL_WLEV = 3;
    localparam int STAT_POL  = 0;
    localparam int STAT_LAT  = 1;
    localparam int STAT_BUSY = 2;
    localparam int STAT_WFB  = 3;
    localparam int STAT_VLD  = 4;
    localparam logic [ISI_W-1:0]  ISI_RST  = 3'h0;
    localparam logic [WLEV_W-1:0] WLEV_RST = 4'h0;

    // =====================================================================
    // Types
    typedef enum logic [1:0] {
        DIO_MODE_SDR = 2'h0,
        DIO_MODE_DDR = 2'h1,
        DIO_MODE_X2  = 2'h2
    } dio_mode_t;

    typedef enum logic [2:0] {
        RD_IDLE  = 3'h1,
        RD_WAIT  = 3'h2,
        RD_BURST = 3'h4
    } dio_rd_st_t;

    typedef struct packed {
        logic            ph;
        logic [DQ_W-1:0] data;
    } dio_cap_t;

    typedef struct packed {
        dio_mode_t         mode;
        logic              rlat;
        logic              wlev_en;
        logic [WLEV_W-1:0] wlev_dly;
    } dio_cfg_t;

    localparam dio_cfg_t CFG_RST = '{DIO_MODE_SDR, 1'b0, 1'b0, WLEV_RST};

endpackage

// ===== test/dio_mem_model.sv
module dio_mem_model #(
    parameter int BURST_LEN = 4
) (
    // Bench control
    input  wire logic                     go_i,
    input  wire logic [7:0]               lead_i,
    // Memory pins
    output logic                          strobe_o,
    output logic      [dio_pkg::DQ_W-1:0] dq_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [dio_pkg::DQ_W-1:0] sent [$];
    logic [dio_pkg::DQ_W-1:0] word = 8'h3c;

    // =====================================================================
    // Idle strobe
    // termination holds it low
    initial
    begin
        strobe_o = 1'b0;
        dq_o     = 8'hc3;
    end

    // =====================================================================
    // Read burst
    // preamble drives low
    always @(posedge go_i)
    begin
        #(lead_i);
        strobe_o = 1'b0;
        #40;
        for (int k = 0; k < BURST_LEN; k++)
        begin
            word = {word[6:0], word[7] ^ word[5]} + 8'h17;
            dq_o = word;
            sent.push_back(word);
            #20 strobe_o = 1'b1;
            #40 strobe_o = 1'b0;
            #20;
        end
        // The inverse after release keeps stale data from passing for a word.
        dq_o = ~dq_o;
    end
endmodule

// ===== test/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int BL = 4;

    logic                              clk = 1'b0;
    logic                              rst_n = 1'b0;
    logic                              ce = 1'b1;
    logic                              fast_a = 1'b0;
    logic                              strobe;
    logic [dio_pkg::ADDR_W-1:0]        addr = '0;
    logic [31:0]                       wdata = '0;
    logic                              wr = 1'b0;
    logic                              rd = 1'b0;
    logic [31:0]                       rdata;
    logic                              ts = 1'b1;
    logic [dio_pkg::LANES-1:0]         din = '0;
    logic [dio_pkg::LANES-1:0]         dout;
    logic [35:0]                       isi;
    logic                              oe;
    logic [7:0]                        dq;
    logic                              rd_start = 1'b0;
    logic [7:0]                        rd_data;
    logic                              rd_valid;
    logic                              pol;
    logic                              lat;
    logic                              wl_fb = 1'b0;
    logic                              wl_en;
    logic [3:0]                        wl_dly;
    logic [7:0]                        lead = 8'd2;
    logic                              exp_pol = 1'b0;
    logic                              rise_seen = 1'b1;
    logic [2:0]                        isi_set [12];
    logic [31:0]                       v;
    logic [31:0]                       lo = '0;
    logic [31:0]                       hi = '0;
    logic [dio_pkg::ADDR_W-1:0]        offs [5] = '{dio_pkg::OFF_CTRL, dio_pkg::OFF_ISI_LO,
                                          dio_pkg::OFF_ISI_HI, dio_pkg::OFF_WLEV, 5'h14};
    int                                err_count = 0;
    int                                num_checks = 0;
    int                                seed = 36;
    int                                ph_cnt = 0;

    always #4 clk = ~clk;
    always #2 fast_a = ~fast_a;

    // System clock phase: one toggle per running edge. The two edges lost to the reset
    // release leave its parity unchanged.
    always @(posedge clk)
        if (rst_n && ce)
            ph_cnt <= ph_cnt + 1;

    // Expected capture polarity: the clock phase at the first strobe rise of a read.
    always @(posedge strobe)
        if (!rise_seen)
        begin
            exp_pol   = ph_cnt[0];
            rise_seen = 1'b1;
        end

    dio_edge_io #(
        .LANES     (dio_pkg::LANES),
        .BURST_LEN (BL)
    ) i_dio_edge_io (
        .ref_clk_i               (clk),
        .reset_n_i               (rst_n),
        .ce_i                    (ce),
        .fast_gear_clk_a_i       (fast_a),
        .fast_gear_clk_b_i       (~fast_a),
        .strobe_clk_i            (strobe),
        .reg_addr_i              (addr),
        .reg_wdata_i             (wdata),
        .reg_wr_i                (wr),
        .reg_rd_i                (rd),
        .reg_rdata_o             (rdata),
        .tristate_ctl_in_i       (ts),
        .out_data_i              (din),
        .out_data_o              (dout),
        .isi_stretch_o           (isi),
        .buf_oe_o                (oe),
        .rd_dq_i                 (dq),
        .rd_start_i              (rd_start),
        .rd_data_o               (rd_data),
        .rd_valid_o              (rd_valid),
        .read_capture_polarity_o (pol),
        .read_capture_latency_o  (lat),
        .wr_lev_fb_i             (wl_fb),
        .wr_lev_en_o             (wl_en),
        .wr_lev_delay_o          (wl_dly)
    );

    dio_mem_model #(
        .BURST_LEN (BL)
    ) i_dio_mem_model (
        .go_i     (rd_start),
        .lead_i   (lead),
        .strobe_o (strobe),
        .dq_o     (dq)
    );

    // =====================================================================
    // Shared tasks
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        v = rdata;
        chk(36'(v), 36'(e), "register");
    endtask

    // Output pipeline: a word taken at one edge shows after the next one.
    task automatic stream(input int n, input logic geared);
        logic [11:0] h [$];
        logic [11:0] d;
        logic [35:0] ex;
        int          s;
        for (int k = 0; k < n; k++)
        begin
            @(posedge clk);
            d = 12'($random(seed));
            din <= d;
            h.push_back(d);
            #1;
            s = h.size();
            if (s >= 4)
            begin
                for (int i = 0; i < 12; i++)
                    ex[3*i +: 3] = (geared && h[s-4][i] != h[s-3][i]
                                    && h[s-3][i] != h[s-2][i]) ? isi_set[i] : 3'h0;
                chk(36'(dout), 36'(h[s-3]), "data");
                chk(isi, ex, "stretch");
            end
        end
    endtask

    task automatic ts_chk(input logic t);
        @(posedge clk);
        ts <= t;
        repeat (4) @(posedge clk);
        #1;
        chk(36'(oe), 36'(!t), "enable");
    endtask

    task automatic rd_burst(input logic want, input logic lt);
        int got;
        wr_reg(dio_pkg::OFF_CTRL, {29'h0, lt, 2'h0});
        @(posedge clk);
        // The lead only steers which polarity is exercised; the check uses the measured phase.
        lead = (want == ph_cnt[0]) ? 8'd2 : 8'd6;
        rise_seen = 1'b0;
        rd_start <= 1'b1;
        @(posedge clk);
        rd_start <= 1'b0;
        got = 0;
        for (int t = 0; t < 300 && got < BL; t++)
        begin
            @(posedge clk);
            #1;
            if (rd_valid === 1'b1)
            begin
                chk(36'(rd_data), 36'(i_dio_mem_model.sent.pop_front()), "rdata");
                chk(36'({pol, lat}), 36'({exp_pol, lt}), "capture");
                got++;
            end
        end
        if (got != BL)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: read burst timed out", $time);
            final_report();
        end
        repeat (8) @(posedge clk);
        $display("test read lead %0d done", lead);
    endtask

    // =====================================================================
    // Main sequence
    initial
    begin
        for (int i = 0; i < 12; i++)
            isi_set[i] = 3'(i + 1);
        repeat (8) @(posedge clk);
        #1;
        chk(36'({oe, wl_en, wl_dly, pol, lat, rd_valid, dout}), '0, "reset");
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        wr_reg(5'h14, 32'hffffffff);
        for (int i = 0; i < 5; i++)
            rd_chk(offs[i], 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 8; i++)
            lo[3*i +: 3] = isi_set[i];
        for (int i = 8; i < 12; i++)
            hi[3*(i-8) +: 3] = isi_set[i];
        wr_reg(dio_pkg::OFF_ISI_LO, lo);
        wr_reg(dio_pkg::OFF_ISI_HI, hi);
        rd_chk(dio_pkg::OFF_ISI_LO, lo);
        rd_chk(dio_pkg::OFF_ISI_HI, hi);
        for (int m = 0; m < 3; m++)
        begin
            wr_reg(dio_pkg::OFF_CTRL, 32'(m));
            rd_chk(dio_pkg::OFF_CTRL, 32'(m));
            stream(40, m == 2);
            ts_chk(1'b0);
            ts_chk(1'b1);
            $display("test mode %0d done", m);
        end
        wr_reg(dio_pkg::OFF_WLEV, 32'hb);
        wr_reg(dio_pkg::OFF_CTRL, 32'h8);
        @(posedge clk);
        wl_fb <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk(36'({wl_en, wl_dly}), 36'h1b, "leveling");
        rd_chk(dio_pkg::OFF_STAT, 32'h8);
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(dio_pkg::OFF_WLEV, 32'h5);
        @(posedge clk);
        ce <= 1'b1;
        rd_chk(dio_pkg::OFF_WLEV, 32'hb);
        $display("test leveling done");
        rd_burst(1'b0, 1'b0);
        rd_burst(1'b1, 1'b1);
        rd_burst(1'b0, 1'b1);
        rd_burst(1'b1, 1'b0);
        final_report();
    end
endmodule
